// [core/vks_pkg.sv]
// Shared constants and carrier types for the display and keyscan controller
package vks_pkg;

    // ----------------------------------------------------------------
    // Sizes and frames
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam logic [5:0] SEG_FRAME  = 6'h1E;
    localparam logic [5:0] DIM_FRAME  = 6'h0D;
    localparam logic [5:0] MODE_FRAME = 6'h03;
    localparam logic [2:0] MODE_ALL  = 3'h0;
    localparam logic [2:0] MODE_G3   = 3'h3;
    localparam logic [2:0] MODE_DIM  = 3'h4;
    localparam logic [2:0] MODE_STOP = 3'h5;
    localparam logic [2:0] MODE_KEY  = 3'h6;
    localparam logic [2:0] MODE_ADC  = 3'h7;
    localparam logic [9:0] DIM_MAX   = 10'h3F8;
    localparam logic [9:0] DIM_RESET = 10'h000;
    localparam logic [2:0] GRID_RESET = 3'h7;
    localparam logic [4:0] COL_IDLE  = 5'h1F;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int BIT_TIME_NS   = 1212;
    localparam int BIT_CYC       = (BIT_TIME_NS * CLK_MHZ) / 1000;
    localparam int KEY_PULSE_US  = 39;
    localparam int KEY_PULSE_CYC = KEY_PULSE_US * CLK_MHZ;
    localparam int FILT_NS       = 620;
    localparam int FILT_CYC      = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] BIT_LAST  = 5'(BIT_CYC - 1);
    localparam logic [9:0] KEY_LAST  = 10'(KEY_PULSE_CYC - 1);
    localparam logic [4:0] FILT_LAST = 5'(FILT_CYC - 1);

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cs;
        logic sclk;
        logic sdata;
    } vks_host_t;

    typedef struct packed {
        logic [26:0] anode;
        logic [2:0]  grid_n;
        logic        dim;
        logic [1:0]  sync;
    } vks_disp_t;

endpackage

// [core/vks_glitch_filter.sv]
// Encoder phase synchroniser and glitch filter
`timescale 1ns/1ns
module vks_glitch_filter (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic raw,
    output logic      clean
);
    import vks_pkg::*;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [4:0] cnt;
        logic       out;
    } vks_filt_t;

    vks_filt_t q;
    vks_filt_t d;
    logic      diff;

    assign diff  = q.s2 ^ q.out;
    assign clean = q.out;

    // ----------------------------------------------------------------
    // Filter
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        if (!diff) begin
            d.cnt = 5'h00;
        end else if (q.cnt == FILT_LAST) begin
            d.cnt = 5'h00;
            d.out = q.s2;
        end else begin
            d.cnt = q.cnt + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    filt_stable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $changed(q.out) |-> $past(diff, 8))
        else $error("encoder output changed without a stable input");

endmodule

// [core/vks_ctrl.sv]
// Serial port, keyscan, dimming and digit multiplex of the display controller
`timescale 1ns/1ns
module vks_ctrl (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire vks_pkg::vks_host_t host_i,
    output logic                    sdata_o,
    output logic                    sdata_oe_n,
    input  wire logic               duty_select,
    input  wire logic [4:0]         return_sense_lines,
    output logic [4:0]              scan_drive_lines,
    input  wire logic [1:0]         encoder_phase_inputs,
    input  wire logic [47:0]        analog_channels,
    output vks_pkg::vks_disp_t      disp_o,
    output logic                    key_int
);
    import vks_pkg::*;

    typedef struct packed {
        logic [2:0]       h1;
        logic [2:0]       h2;
        logic             sclk_p;
        logic             cs_p;
        logic [4:0]       col1;
        logic [4:0]       col2;
        logic             dup1;
        logic             dup2;
        logic [29:0]      sr;
        logic [5:0]       cnt;
        logic             rd_arm;
        logic [2:0]       rd_mode;
        logic             rd;
        logic [47:0]      osr;
        logic             dout;
        logic             oe_n;
        logic [2:0][26:0] seg;
        logic [9:0]       duty;
        logic             scan;
        logic [2:0]       row_idx;
        logic [9:0]       kcnt;
        logic [4:0]       rows;
        logic [24:0]      keys;
        logic             kint;
        logic [4:0]       col_ref;
        logic [4:0]       bcnt;
        logic [9:0]       dcnt;
        logic [1:0]       slot;
        vks_disp_t        disp;
    } vks_st_t;

    localparam vks_st_t ST_RST = '{
        disp:    '{grid_n: GRID_RESET, default: '0},
        duty:    DIM_RESET,
        oe_n:    1'b1,
        col1:    COL_IDLE,
        col2:    COL_IDLE,
        col_ref: COL_IDLE,
        default: '0
    };

    vks_st_t     st_q;
    vks_st_t     st_d;
    logic        cs_s;
    logic        sclk_s;
    logic        dat_s;
    logic        sclk_rise;
    logic        cs_fall;
    logic        cs_rise;
    logic [2:0]  md;
    logic [26:0] seg_rx;
    logic [9:0]  dim_rx;
    logic [1:0]  enc_f;
    logic        stop_cmd;

    // second flop of each host synchroniser is the only reader
    assign cs_s      = st_q.h2[2];
    assign sclk_s    = st_q.h2[1];
    assign dat_s     = st_q.h2[0];
    assign sclk_rise = cs_s & sclk_s & ~st_q.sclk_p;
    assign cs_fall   = st_q.cs_p & ~cs_s;
    assign cs_rise   = ~st_q.cs_p & cs_s;
    // Function code arrives last: M0 is the oldest of the final three bits
    assign md        = {st_q.sr[0], st_q.sr[1], st_q.sr[2]};
    assign stop_cmd  = cs_fall & ~st_q.rd & (st_q.cnt == MODE_FRAME) & (md == MODE_STOP);

    // ----------------------------------------------------------------
    // Payload bit order: first received bit is the lowest field bit
    // ----------------------------------------------------------------
    for (genvar k = 0; k < 27; k++) begin : g_rev
        assign seg_rx[k] = st_q.sr[29-k];
        if (k < 10) begin : g_dim
            assign dim_rx[k] = st_q.sr[12-k];
        end
    end

    for (genvar e = 0; e < 2; e++) begin : g_enc
        vks_glitch_filter u_filt (
            .ref_clk (ref_clk),
            .arst_n  (arst_n),
            .raw     (encoder_phase_inputs[e]),
            .clean   (enc_f[e])
        );
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.h1     = {host_i.cs, host_i.sclk, host_i.sdata};
        st_d.h2     = st_q.h1;
        st_d.sclk_p = sclk_s;
        st_d.cs_p   = cs_s;
        // return lines are only synchronised, never debounced
        st_d.col1   = return_sense_lines;
        st_d.col2   = st_q.col1;
        st_d.dup1   = duty_select;
        st_d.dup2   = st_q.dup1;

        if (cs_rise) begin
            st_d.cnt = 6'h00;
            if (st_q.rd_arm) begin
                st_d.rd     = 1'b1;
                st_d.rd_arm = 1'b0;
                st_d.osr    = (st_q.rd_mode == MODE_ADC) ? analog_channels :
                              {19'h00000, 1'b0, enc_f, st_q.scan, st_q.keys};
                st_d.dout   = st_d.osr[0];
            end
        end else if (sclk_rise) begin
            // one bit per serial clock rise
            st_d.sr = {st_q.sr[28:0], dat_s};
            if (st_q.cnt != 6'h3F) begin
                st_d.cnt = st_q.cnt + 6'h01;
            end
            if (st_q.rd) begin
                st_d.dout = st_q.osr[1];
                st_d.osr  = {1'b0, st_q.osr[47:1]};
            end
        end

        if (cs_fall) begin
            st_d.rd = 1'b0;
            // latch transfer at chip select fall
            // code taken from the last three bits
            if (!st_q.rd) begin
                if (st_q.cnt == SEG_FRAME && md == MODE_ALL) begin
                    st_d.seg = {3{seg_rx}};
                end else if (st_q.cnt == SEG_FRAME && md <= MODE_G3) begin
                    st_d.seg[md - 3'h1] = seg_rx;
                end else if (st_q.cnt == DIM_FRAME && md == MODE_DIM) begin
                    st_d.duty = dim_rx;
                end else if (st_q.cnt == MODE_FRAME && md >= MODE_KEY) begin
                    st_d.rd_arm  = 1'b1;
                    st_d.rd_mode = md;
                end
            end
        end
        // drive the data line only while reading
        st_d.oe_n = ~st_d.rd;

        // key change starts the scan, full cycle raises the interrupt
        st_d.col_ref = st_q.col2;
        if (!st_q.scan) begin
            if (st_q.col2 != st_q.col_ref) begin
                st_d.scan    = 1'b1;
                st_d.row_idx = 3'h0;
                st_d.kcnt    = 10'h000;
            end
        end else if (st_q.kcnt == KEY_LAST) begin
            st_d.kcnt = 10'h000;
            st_d.keys[st_q.row_idx*5 +: 5] = ~st_q.col2;
            if (st_q.row_idx == 3'h4) begin
                st_d.row_idx = 3'h0;
                st_d.kint    = 1'b1;
            end else begin
                st_d.row_idx = st_q.row_idx + 3'h1;
            end
        end else begin
            st_d.kcnt = st_q.kcnt + 10'h001;
        end
        if (stop_cmd) begin
            st_d.scan = 1'b0;
            st_d.kint = 1'b0;
        end
        // selected row pulled low, all low when idle
        st_d.rows = st_d.scan ? ~(5'h01 << st_d.row_idx) : 5'h00;

        // Bit-time divider feeds the duty counter
        if (st_q.bcnt == BIT_LAST) begin
            st_d.bcnt = 5'h00;
            st_d.dcnt = st_q.dcnt + 10'h001;
            if (st_q.dcnt == 10'h3FF) begin
                // half duty uses two slots, one-third uses three
                st_d.slot = (st_q.slot == (st_q.dup2 ? 2'h1 : 2'h2)) ? 2'h0
                                                                     : st_q.slot + 2'h1;
            end
        end else begin
            st_d.bcnt = st_q.bcnt + 5'h01;
        end
        // Switching to half duty mid-frame must not leave the third digit on
        if (st_q.dup2 && st_q.slot == 2'h2) begin
            st_d.slot = 2'h0;
        end

        // pulse width from the 10-bit duty, capped at DIM_MAX
        // the same pulse leaves on its own pin
        st_d.disp.dim    = st_q.dcnt < ((st_q.duty > DIM_MAX) ? DIM_MAX : st_q.duty);
        st_d.disp.grid_n = st_q.disp.dim ? ~(3'h1 << st_q.slot) : GRID_RESET;
        st_d.disp.anode  = st_q.disp.dim ? st_q.seg[st_q.slot] : 27'h0000000;
        st_d.disp.sync   = {st_q.slot == 2'h1, st_q.slot == 2'h0};
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign sdata_o          = st_q.dout;
    assign sdata_oe_n       = st_q.oe_n;
    assign scan_drive_lines = st_q.rows;
    assign disp_o           = st_q.disp;
    assign key_int          = st_q.kint;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence cs_fall_s;
        st_q.cs_p && !cs_s && !st_q.rd;
    endsequence

    sequence seg_all_s;
        cs_fall_s ##0 (st_q.cnt == SEG_FRAME) && (md == MODE_ALL);
    endsequence

    cs_gate_shift_a: assert property (!cs_s |=> $stable(st_q.sr))
        else $error("shifter moved with chip select low");
    clk_edge_count_a: assert property (sclk_rise && !cs_rise && st_q.cnt < 6'h10
        |=> st_q.cnt == $past(st_q.cnt) + 6'h01)
        else $error("bit count missed a serial clock rise");
    seg_latch_a: assert property (seg_all_s |=> st_q.seg[2] == $past(seg_rx)
        && st_q.seg[0] == st_q.seg[1])
        else $error("segment latches not loaded on chip select fall");
    int_after_scan_a: assert property ($rose(st_q.kint) |-> $past(st_q.scan)
        && $past(st_q.row_idx) == 3'h4)
        else $error("interrupt rose without a completed scan");
    rows_pattern_a: assert property (st_q.scan |-> $onehot(~st_q.rows))
        else $error("scan lines not a single active row");
    stop_clears_a: assert property (stop_cmd |=> !st_q.kint ##1 st_q.rows == 5'h00)
        else $error("stop did not clear interrupt and rows");
    oe_readout_a: assert property (!st_q.oe_n |-> st_q.rd && st_q.cs_p)
        else $error("data line driven outside readout");
    digit_single_a: assert property ($onehot0(~st_q.disp.grid_n))
        else $error("more than one digit selected");
    duplex_slots_a: assert property (st_q.dup2 && $past(st_q.dup2) |-> st_q.slot != 2'h2)
        else $error("third slot used in half duty");
    dim_zero_a: assert property (st_q.duty == DIM_RESET [*2] |=> !st_q.disp.dim
        && st_q.disp.anode == 27'h0000000)
        else $error("brightness pulse with zero duty");

endmodule

// [sim/vks_host_model.sv]
// Host controller model on the three-wire serial port
`timescale 1ns/1ns
module vks_host_model (
    input  wire logic          ref_clk,
    input  wire logic          sdata_o,
    input  wire logic          sdata_oe_n,
    output vks_pkg::vks_host_t host_o
);
    import vks_pkg::*;
    logic cs = 1'b0, sclk = 1'b0, drv_on = 1'b0, drv_bit = 1'b0;
    logic last_q = 1'b0;
    logic line;
    // device owns line
    // Nobody driving: toggle each cycle so a stale level never reads as data
    assign line   = !sdata_oe_n ? sdata_o : (drv_on ? drv_bit : ~last_q);
    assign host_o = '{cs: cs, sclk: sclk, sdata: line};
    always_ff @(posedge ref_clk) last_q <= line;
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic open_frame(input logic drive);
        cs     = 1'b1;
        drv_on = drive;
        tick(4);
    endtask
    task automatic send_bit(input logic b);
        drv_bit = b;
        tick(4);
        sclk = 1'b1;
        tick(4);
        sclk = 1'b0;
    endtask
    task automatic close_frame();
        tick(4);
        cs     = 1'b0;
        drv_on = 1'b0;
        tick(20);
    endtask
    task automatic write_code(input logic [2:0] m);
        int i;
        open_frame(1'b1);
        for (i = 0; i < 3; i++) send_bit(m[i]);
        close_frame();
    endtask
    task automatic write_seg(input logic [26:0] s, input logic [2:0] m);
        int i;
        open_frame(1'b1);
        for (i = 0; i < 27; i++) send_bit(s[i]);
        for (i = 0; i < 3; i++) send_bit(m[i]);
        close_frame();
    endtask
    // bit 0 before first rise, next bit after each rise
    task automatic read_word(input logic [2:0] m, output logic [47:0] w, output logic oe_n);
        int i;
        write_code(m);
        open_frame(1'b0);
        tick(4);
        oe_n = sdata_oe_n;
        for (i = 0; i < 48; i++) begin
            w[i] = line;
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            tick(4);
        end
        close_frame();
    endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the display and keyscan controller
`timescale 1ns/1ns
module tb;
    import vks_pkg::*;
    localparam logic [47:0] ADC_WORD = 48'hA53C960FE178;
    // Triplex from the start so the third digit is reached within the run
    logic        ref_clk = 1'b0, arst_n = 1'b0, duty_select = 1'b0, key_down = 1'b0;
    logic        oe_n_seen, sdata_o, sdata_oe_n, key_int;
    logic [1:0]  encoder_phase_inputs = 2'h0;
    logic [4:0]  return_sense_lines, scan_drive_lines;
    logic [47:0] word, adc_word = ADC_WORD;
    vks_host_t   host_i;
    vks_disp_t   disp_o;
    int          mismatches = 0, tests_run = 0, n;
    vks_host_model host (.ref_clk(ref_clk), .sdata_o(sdata_o), .sdata_oe_n(sdata_oe_n),
                         .host_o(host_i));
    vks_ctrl dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .host_i(host_i),
        .sdata_o(sdata_o), .sdata_oe_n(sdata_oe_n), .duty_select(duty_select),
        .return_sense_lines(return_sense_lines), .scan_drive_lines(scan_drive_lines),
        .encoder_phase_inputs(encoder_phase_inputs), .analog_channels(adc_word),
        .disp_o(disp_o), .key_int(key_int)
    );
    // Key at row index 2, column index 3 pulls its column low while its row is low
    assign return_sense_lines = (key_down && !scan_drive_lines[2]) ? 5'h17 : COL_IDLE;
    initial forever #20 ref_clk = ~ref_clk;
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic give_up();
        mismatches++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        close_out();
    endtask
    initial begin
        host.tick(3);
        arst_n = 1'b1;
        host.tick(1);
        check(48'({scan_drive_lines, key_int, disp_o.dim}), 48'h0, "reset outputs");
        check(48'(disp_o.anode), 48'h0, "reset anodes");
        check(48'({disp_o.grid_n, sdata_oe_n}), 48'hF, "reset digits, line");
        $display("test reset done");
        host.open_frame(1'b1);
        for (n = 0; n < 13; n++) host.send_bit(n < 10 ? 1'b1 : MODE_DIM[n - 10]);
        host.close_frame();
        host.write_seg(27'h2AAAAAA, MODE_ALL);
        host.write_seg(27'h1234567, 3'h2);
        for (n = 0; n < 40000 && disp_o.grid_n !== 3'h6; n++) host.tick(1);
        if (n == 40000) give_up();
        host.tick(2);
        check(48'(disp_o.anode), 48'h2AAAAAA, "digit 1 anodes");
        check(48'({disp_o.dim, disp_o.sync}), 48'h5, "dim, sync slot 0");
        $display("test display done");
        encoder_phase_inputs = 2'h1;
        host.tick(10);
        encoder_phase_inputs = 2'h2;
        key_down = 1'b1;
        host.tick(5);
        check(48'(scan_drive_lines), 48'h1E, "first row");
        host.tick(4000);
        check(48'(key_int), 48'h0, "flag too early");
        for (n = 0; n < 1500 && key_int !== 1'b1; n++) host.tick(1);
        if (n == 1500) give_up();
        host.read_word(MODE_KEY, word, oe_n_seen);
        check(word, 48'h0A002000, "key word");
        check(48'({oe_n_seen, sdata_oe_n}), 48'h1, "line turnaround");
        $display("test keyscan done");
        host.open_frame(1'b1);
        for (n = 0; n < 4; n++) host.send_bit(n[0]);
        host.close_frame();
        check(48'(key_int), 48'h1, "long stop frame");
        // Stop while the held key's row is active, so idle rows leave its column unchanged
        for (n = 0; n < 5000 && scan_drive_lines !== 5'h1B; n++) host.tick(1);
        if (n == 5000) give_up();
        host.write_code(MODE_STOP);
        check(48'({key_int, scan_drive_lines}), 48'h0, "stop");
        key_down = 1'b0;
        host.tick(5);
        check(48'(scan_drive_lines), 48'h1E, "release scan");
        $display("test stop done");
        host.read_word(MODE_ADC, word, oe_n_seen);
        check(word, ADC_WORD, "converter word");
        adc_word = ~ADC_WORD;
        host.read_word(MODE_ADC, word, oe_n_seen);
        check(word, ~ADC_WORD, "converter word 2");
        $display("test converter done");
        for (n = 0; n < 40000 && disp_o.grid_n !== 3'h5; n++) host.tick(1);
        if (n == 40000) give_up();
        host.tick(2);
        check(48'(disp_o.anode), 48'h1234567, "digit 2 anodes");
        check(48'(disp_o.sync), 48'h2, "sync slot 1");
        for (n = 0; n < 40000 && disp_o.grid_n !== 3'h7; n++) host.tick(1);
        if (n == 40000) give_up();
        for (n = 0; n < 40000 && disp_o.grid_n === 3'h7; n++) host.tick(1);
        if (n == 40000) give_up();
        check(48'(disp_o.grid_n), 48'h3, "triplex order");
        check(48'(disp_o.anode), 48'h2AAAAAA, "digit 3 anodes");
        duty_select = 1'b1;
        host.tick(5);
        check(48'(disp_o.grid_n), 48'h6, "duplex order");
        $display("test duty done");
        close_out();
    end
endmodule
